/* File: logic/halfword_pack_extend_unit.sv */
// Halfword pack and byte/halfword widen datapath, one cycle latency
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Bottom-top pack keeps first operand low half in result low half.
// - Bottom-top pack puts shifted second operand upper half in result upper half.
// - Top-bottom pack keeps first operand upper half in result upper half.
// - Top-bottom pack puts shifted second operand low half in result low half.
// - Bottom-top left shift of 1 to 31; zero means no shift.
// - Top-bottom arithmetic right shift 1 to 32; code zero means 32.
// - Without a named destination, result goes to the first operand register.
// - Pack and widen operations never request a flag update.
// - Signed halfword widen copies bit 15 into all upper bits.
// - Unsigned halfword widen fills upper 16 bits with zeros.
// - Halfword widen-add widens to 32 bits then adds first operand.
// - Byte widen-add widens to 32 bits then adds first operand.
// - Dual unsigned widen-add adds two zero-widened bytes to matching halfwords.
// - Every widen first rotates source right by 0, 8, 16 or 24.
// - Dual forms take rotated bits 7:0 and 23:16 into own lanes.
// - Widen-add adds to whole word, or per halfword in dual forms.
module halfword_pack_extend_unit
    import pack_extend_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_in,
    input  wire logic                 clk_en_in,
    // Operation from decoder
    input  wire logic                 op_valid_in,
    input  wire logic [3:0]           op_sel_in,
    input  wire logic [WORD_W-1:0]    first_operand_in,
    input  wire logic [WORD_W-1:0]    second_operand_in,
    input  wire logic [SHAMT_W-1:0]   shift_amount_in,
    input  wire logic [ROT_SEL_W-1:0] rotate_sel_in,
    // Destination selection
    input  wire logic                 dest_named_in,
    input  wire logic [REG_SEL_W-1:0] dest_reg_in,
    input  wire logic [REG_SEL_W-1:0] first_operand_reg_in,
    // Write-back
    output logic                      result_valid_out,
    output logic      [WORD_W-1:0]    result_out,
    output logic      [REG_SEL_W-1:0] result_reg_out,
    output logic                      flags_update_out
);
    pack_op_t          op;
    logic [WORD_W-1:0] next_result;
    logic [WORD_W-1:0] shl_val;
    logic [WORD_W-1:0] asr_val;
    logic [WORD_W-1:0] rotated;
    logic [WORD_W-1:0] widened;
    logic [WORD_W-1:0] word_sum;
    logic [HALF_W-1:0] lane_lo;
    logic [HALF_W-1:0] lane_hi;
    logic              is_signed;
    logic              is_dual_add;
    logic [4:0]        rot_amt;

    assign op = pack_op_t'(op_sel_in);

    // Logical left shift for the bottom-top pack
    always_comb begin
        shl_val = second_operand_in << shift_amount_in;
    end

    // Arithmetic right shift for the top-bottom pack
    always_comb begin
        if (shift_amount_in == SHAMT_FULL_CODE) begin
            // Shift of 32 leaves only sign copies, same as a shift of 31
            asr_val = {WORD_W{second_operand_in[WORD_W-1]}};
        end else begin
            asr_val = WORD_W'($signed(second_operand_in) >>> shift_amount_in);
        end
    end

    // Rotate ahead of extraction
    always_comb begin
        rot_amt = 5'(rotate_sel_in * ROT_STEP);
        rotated = (second_operand_in >> rot_amt) | (second_operand_in << (6'h20 - {1'b0, rot_amt}));
        if (rotate_sel_in == ROT_NONE) begin
            rotated = second_operand_in;
        end
    end

    // Operation class decode; unknown codes fall to the unsigned plain forms
    always_comb begin
        case (op)
            OP_SIGNED_HALF_WIDEN,
            OP_SIGNED_BYTE_WIDEN,
            OP_DUAL_SIGNED_BYTE_WIDEN,
            OP_SIGNED_HALF_WIDEN_ADD,
            OP_SIGNED_BYTE_WIDEN_ADD: begin
                is_signed   = 1'b1;
                is_dual_add = 1'b0;
            end
            OP_DUAL_SIGNED_BYTE_WIDEN_ADD: begin
                is_signed   = 1'b1;
                is_dual_add = 1'b1;
            end
            OP_DUAL_UNSIGNED_BYTE_WIDEN_ADD: begin
                is_signed   = 1'b0;
                is_dual_add = 1'b1;
            end
            default: begin
                is_signed   = 1'b0;
                is_dual_add = 1'b0;
            end
        endcase
    end

    // Dual lanes, low from bits 7:0 and high from bits 23:16
    lane_widen u_lane_lo (
        .byte_in   (rotated[7:0]),
        .signed_in (is_signed),
        .addend_in (first_operand_in[15:0]),
        .add_en_in (is_dual_add),
        .lane_out  (lane_lo)
    );

    lane_widen u_lane_hi (
        .byte_in   (rotated[23:16]),
        .signed_in (is_signed),
        .addend_in (first_operand_in[31:16]),
        .add_en_in (is_dual_add),
        .lane_out  (lane_hi)
    );

    // Word-wide widening for single forms
    always_comb begin
        case (op)
            OP_SIGNED_HALF_WIDEN,
            OP_SIGNED_HALF_WIDEN_ADD: begin
                widened = {{HALF_W{rotated[15]}}, rotated[15:0]};
            end
            OP_UNSIGNED_HALF_WIDEN,
            OP_UNSIGNED_HALF_WIDEN_ADD: begin
                widened = {{HALF_W{1'b0}}, rotated[15:0]};
            end
            OP_SIGNED_BYTE_WIDEN,
            OP_SIGNED_BYTE_WIDEN_ADD: begin
                widened = {{(WORD_W-BYTE_W){rotated[7]}}, rotated[7:0]};
            end
            default: begin
                widened = {{(WORD_W-BYTE_W){1'b0}}, rotated[7:0]};
            end
        endcase
        word_sum = WORD_W'(widened + first_operand_in);
    end

    // Result select
    always_comb begin
        case (op)
            OP_PACK_BOTTOM_TOP: begin
                next_result = {shl_val[31:16], first_operand_in[15:0]};
            end
            OP_PACK_TOP_BOTTOM: begin
                next_result = {first_operand_in[31:16], asr_val[15:0]};
            end
            OP_SIGNED_HALF_WIDEN,
            OP_UNSIGNED_HALF_WIDEN,
            OP_SIGNED_BYTE_WIDEN,
            OP_UNSIGNED_BYTE_WIDEN: begin
                next_result = widened;
            end
            OP_DUAL_SIGNED_BYTE_WIDEN,
            OP_DUAL_UNSIGNED_BYTE_WIDEN,
            OP_DUAL_SIGNED_BYTE_WIDEN_ADD,
            OP_DUAL_UNSIGNED_BYTE_WIDEN_ADD: begin
                next_result = {lane_hi, lane_lo};
            end
            OP_SIGNED_HALF_WIDEN_ADD,
            OP_UNSIGNED_HALF_WIDEN_ADD,
            OP_SIGNED_BYTE_WIDEN_ADD,
            OP_UNSIGNED_BYTE_WIDEN_ADD: begin
                next_result = word_sum;
            end
            // Unknown codes give zero so write-back is never stale
            default: begin
                next_result = RESULT_RESET;
            end
        endcase
    end

    // Valid strobe
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            result_valid_out <= 1'b0;
        end else if (clk_en_in) begin
            result_valid_out <= op_valid_in;
        end
    end

    // Result word; held between valid operations
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            result_out <= RESULT_RESET;
        end else if (clk_en_in && op_valid_in) begin
            result_out <= next_result;
        end
    end

    // Destination index travels with its result
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            result_reg_out <= '0;
        end else if (clk_en_in && op_valid_in) begin
            // Destination legality is the issuer's job, not checked here
            result_reg_out <= dest_named_in ? dest_reg_in : first_operand_reg_in;
        end
    end

    // None of these operations touch the condition flags
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            flags_update_out <= 1'b0;
        end else if (clk_en_in) begin
            flags_update_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: logic/lane_widen.sv */
// One byte to halfword widening lane with optional halfword add
`timescale 1ns/1ps
`default_nettype none
module lane_widen
    import pack_extend_pkg::*;
(
    // Lane inputs
    input  wire logic [BYTE_W-1:0] byte_in,
    input  wire logic              signed_in,
    input  wire logic [HALF_W-1:0] addend_in,
    input  wire logic              add_en_in,
    // Lane result
    output logic      [HALF_W-1:0] lane_out
);
    logic [HALF_W-1:0] widened;

    always_comb begin
        widened  = {{(HALF_W-BYTE_W){signed_in & byte_in[BYTE_W-1]}}, byte_in};
        // Carry out of the lane is dropped, lanes never interact
        lane_out = add_en_in ? HALF_W'(widened + addend_in) : widened;
    end
endmodule
`default_nettype wire

/* File: logic/pack_extend_pkg.sv */
// Operation codes, field widths and shift encodings for the pack and widen unit
package pack_extend_pkg;

    localparam int unsigned WORD_W      = 32;
    localparam int unsigned HALF_W      = 16;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned SHAMT_W     = 5;
    localparam int unsigned ROT_SEL_W   = 2;
    localparam int unsigned REG_SEL_W   = 4;

    // Rotate select: 0, 8, 16 or 24 bit positions
    localparam logic [ROT_SEL_W-1:0] ROT_NONE = 2'h0;
    localparam int unsigned ROT_STEP      = 8;

    // Encoded arithmetic right shift of zero means a full 32 position shift
    localparam logic [SHAMT_W-1:0] SHAMT_FULL_CODE = 5'h00;

    localparam logic [WORD_W-1:0] RESULT_RESET = 32'h00000000;

    typedef enum logic [3:0] {
        OP_PACK_BOTTOM_TOP             = 4'h0,
        OP_PACK_TOP_BOTTOM             = 4'h1,
        OP_SIGNED_HALF_WIDEN           = 4'h2,
        OP_UNSIGNED_HALF_WIDEN         = 4'h3,
        OP_SIGNED_BYTE_WIDEN           = 4'h4,
        OP_UNSIGNED_BYTE_WIDEN         = 4'h5,
        OP_DUAL_SIGNED_BYTE_WIDEN      = 4'h6,
        OP_DUAL_UNSIGNED_BYTE_WIDEN    = 4'h7,
        OP_SIGNED_HALF_WIDEN_ADD       = 4'h8,
        OP_UNSIGNED_HALF_WIDEN_ADD     = 4'h9,
        OP_SIGNED_BYTE_WIDEN_ADD       = 4'hA,
        OP_UNSIGNED_BYTE_WIDEN_ADD     = 4'hB,
        OP_DUAL_SIGNED_BYTE_WIDEN_ADD  = 4'hC,
        OP_DUAL_UNSIGNED_BYTE_WIDEN_ADD = 4'hD
    } pack_op_t;

endpackage

/* File: verification/halfword_pack_extend_unit_tb_top.sv */
// Self-checking bench for the pack and widen unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module halfword_pack_extend_unit_tb_top;
    import pack_extend_pkg::*;
    logic                 clk_sys_in, rst_in, clk_en_in, op_valid_in, dest_named_in;
    logic                 result_valid_out, flags_update_out;
    logic [3:0]           op_sel_in;
    logic [SHAMT_W-1:0]   shift_amount_in;
    logic [ROT_SEL_W-1:0] rotate_sel_in;
    logic [REG_SEL_W-1:0] dest_reg_in, a_idx, b_idx, result_reg_out;
    logic [WORD_W-1:0]    a_val, b_val, result_out;
    int                   fails = 0, checked = 0;
    operand_rf_model rf (.rd_a_in(a_idx), .rd_b_in(b_idx), .rd_a_out(a_val), .rd_b_out(b_val));
    halfword_pack_extend_unit uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
        .op_valid_in(op_valid_in), .op_sel_in(op_sel_in), .first_operand_in(a_val), .second_operand_in(b_val),
        .shift_amount_in(shift_amount_in), .rotate_sel_in(rotate_sel_in), .dest_named_in(dest_named_in),
        .dest_reg_in(dest_reg_in), .first_operand_reg_in(a_idx), .result_valid_out(result_valid_out),
        .result_out(result_out), .result_reg_out(result_reg_out), .flags_update_out(flags_update_out));
    function automatic logic [31:0] expect_of(logic [3:0] op, logic [31:0] a, b, logic [4:0] sh, logic [1:0] rot);
        logic [31:0] r, t;
        logic [15:0] lo, hi;
        logic        sg;
        r = 32'({b, b} >> (8 * rot));
        sg = !op[0];
        lo = {{8{sg & r[7]}}, r[7:0]};
        hi = {{8{sg & r[23]}}, r[23:16]};
        case (op)
            4'h0: begin t = b << sh; return {t[31:16], a[15:0]}; end
            4'h1: begin
                t = 32'($signed({{32{b[31]}}, b}) >>> (sh == 5'h00 ? 32 : sh));
                return {a[31:16], t[15:0]};
            end
            4'h2, 4'h3, 4'h8, 4'h9: t = {{16{sg & r[15]}}, r[15:0]};
            4'h4, 4'h5, 4'hA, 4'hB: t = {{24{sg & r[7]}}, r[7:0]};
            4'h6, 4'h7, 4'hC, 4'hD: t = op[3] ? {hi + a[31:16], lo + a[15:0]} : {hi, lo};
            default: return 32'h0;
        endcase
        return (op[3] && op < 4'hC) ? t + a : t;
    endfunction
    task automatic issue(logic [3:0] op, logic [31:0] a, b, logic [4:0] sh, logic [1:0] rot, logic [3:0] ai, logic nm);
        @(posedge clk_sys_in);
        #1;
        rf.regs[ai] = a;
        rf.regs[4'h1] = b;
        a_idx = ai;
        b_idx = 4'h1;
        op_sel_in = op;
        shift_amount_in = sh;
        rotate_sel_in = rot;
        dest_named_in = nm;
        dest_reg_in = ai + 4'h1;
        op_valid_in = 1'b1;
    endtask
    task automatic check(logic [31:0] e, logic [3:0] r);
        @(posedge clk_sys_in);
        #1;
        op_valid_in = 1'b0;
        `CHK(result_valid_out, 1'b1)
        `CHK(result_out, e)
        `CHK(result_reg_out, r)
        `CHK(flags_update_out, 1'b0)
    endtask
    task automatic t_all_ops();
        logic [31:0] av [4] = '{32'hFFFF_FFFF, 32'h0000_0001, 32'h8000_7FFF, 32'h1234_ABCD};
        logic [31:0] bv [4] = '{32'h8001_7F80, 32'h1234_5678, 32'hFF00_80FF, 32'h0180_7F01};
        logic [4:0]  sv [4] = '{5'h00, 5'h01, 5'h1F, 5'h04};
        for (int op = 0; op < 16; op++)
            for (int i = 0; i < 4; i++) begin
                issue(4'(op), av[i], bv[i], sv[i], 2'(i), 4'(4 + i), i[0]);
                check(expect_of(4'(op), av[i], bv[i], sv[i], 2'(i)), i[0] ? 4'(5 + i) : 4'(4 + i));
            end
    endtask
    // Back-to-back ops, a frozen enable, then reset in mid-run
    task automatic t_stream();
        issue(4'h0, 32'h1111_AAAA, 32'h0001_2345, 5'h04, 2'h0, 4'h4, 1'b0);
        issue(4'h8, 32'h0000_0001, 32'h8001_0000, 5'h00, 2'h2, 4'h5, 1'b1);
        `CHK(result_out, 32'h0012_AAAA)
        @(posedge clk_sys_in);
        #1;
        // Strobe must stay up across frozen edges, and a request seen then is lost
        clk_en_in = 1'b0;
        op_valid_in = 1'b0;
        `CHK(result_valid_out, 1'b1)
        `CHK(result_out, 32'hFFFF_8002)
        `CHK(result_reg_out, 4'h6)
        `CHK(flags_update_out, 1'b0)
        @(posedge clk_sys_in);
        #1;
        `CHK(result_valid_out, 1'b1)
        op_valid_in = 1'b1;
        op_sel_in = 4'hE;
        @(posedge clk_sys_in);
        #1;
        `CHK(result_out, 32'hFFFF_8002)
        clk_en_in = 1'b1;
        op_valid_in = 1'b0;
        @(posedge clk_sys_in);
        #1;
        `CHK(result_valid_out, 1'b0)
        op_valid_in = 1'b1;
        rst_in = 1'b1;
        @(posedge clk_sys_in);
        #1;
        `CHK({result_valid_out, result_out, result_reg_out}, 37'h0)
        rst_in = 1'b0;
        op_valid_in = 1'b0;
    endtask
    task automatic end_of_test();
        if (fails == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        {rst_in, clk_en_in, op_valid_in, dest_named_in} = 4'hC;
        {op_sel_in, shift_amount_in, rotate_sel_in, dest_reg_in, a_idx, b_idx} = '0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        rst_in = 1'b0;
        t_all_ops();
        t_stream();
        end_of_test();
    end
    // Whole run is under 200 cycles; this cuts a hang long after that
    initial begin
        #100000;
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire

/* File: verification/operand_rf_model.sv */
// Register file model of the operand source in front of the unit
`timescale 1ns/1ps
`default_nettype none
module operand_rf_model
    import pack_extend_pkg::*;
(
    // Read ports
    input  wire logic [REG_SEL_W-1:0] rd_a_in,
    input  wire logic [REG_SEL_W-1:0] rd_b_in,
    output logic      [WORD_W-1:0]    rd_a_out,
    output logic      [WORD_W-1:0]    rd_b_out
);
    // Loaded by the bench; no write-back port, so results are judged at the unit
    logic [WORD_W-1:0] regs [16];
    assign rd_a_out = regs[rd_a_in];
    assign rd_b_out = regs[rd_b_in];
endmodule
`default_nettype wire

/* File: verification/pack_unit_asserts.sv */
// Port assertions for the pack and widen unit
`timescale 1ns/1ps
`default_nettype none
module pack_unit_asserts
    import pack_extend_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_in,
    input  wire logic                 clk_en_in,
    // Operation from decoder
    input  wire logic                 op_valid_in,
    input  wire logic [3:0]           op_sel_in,
    input  wire logic [WORD_W-1:0]    first_operand_in,
    input  wire logic [WORD_W-1:0]    second_operand_in,
    input  wire logic [SHAMT_W-1:0]   shift_amount_in,
    input  wire logic [ROT_SEL_W-1:0] rotate_sel_in,
    // Destination selection
    input  wire logic                 dest_named_in,
    input  wire logic [REG_SEL_W-1:0] dest_reg_in,
    input  wire logic [REG_SEL_W-1:0] first_operand_reg_in,
    // Write-back
    input  wire logic                 result_valid_out,
    input  wire logic [WORD_W-1:0]    result_out,
    input  wire logic [REG_SEL_W-1:0] result_reg_out,
    input  wire logic                 flags_update_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic take;
    assign take = clk_en_in && op_valid_in;
    a_valid_after_op: assert property (take |=> result_valid_out) else $error("valid late");
    a_valid_idle: assert property (
        clk_en_in && !op_valid_in |=> !result_valid_out) else $error("stray valid");
    // Reset check must not be switched off by the reset it watches
    a_reset_clear: assert property (disable iff (1'b0)
        rst_in |=> !result_valid_out && result_out == 32'h0) else $error("reset left state");
    a_flags_quiet: assert property (!flags_update_out) else $error("flag update");
    a_dest_default: assert property (
        take && !dest_named_in |=> result_reg_out == $past(first_operand_reg_in)) else $error("wrong dest");
    a_dest_named: assert property (
        take && dest_named_in |=> result_reg_out == $past(dest_reg_in)) else $error("named dest lost");
    a_pack_low_kept: assert property (
        take && op_sel_in == OP_PACK_BOTTOM_TOP |=> result_out[15:0] == $past(first_operand_in[15:0]))
        else $error("low half lost");
    a_pack_high_kept: assert property (
        take && op_sel_in == OP_PACK_TOP_BOTTOM |=> result_out[31:16] == $past(first_operand_in[31:16]))
        else $error("high half lost");
    a_full_shift_sign: assert property (
        take && op_sel_in == OP_PACK_TOP_BOTTOM && shift_amount_in == SHAMT_FULL_CODE
        |=> result_out[15:0] == {16{$past(second_operand_in[31])}}) else $error("full shift wrong");
    a_half_zero: assert property (
        take && op_sel_in == OP_UNSIGNED_HALF_WIDEN |=> result_out[31:16] == 16'h0000) else $error("no zero fill");
    a_half_sign: assert property (
        take && op_sel_in == OP_SIGNED_HALF_WIDEN |=> result_out[31:16] == {16{result_out[15]}})
        else $error("no sign fill");
    a_result_hold: assert property (
        clk_en_in && !op_valid_in |=> $stable(result_out)) else $error("result moved");
    c_pack: cover property (take && op_sel_in == 4'h1);
    c_dual_add: cover property (take && op_sel_in == 4'hD);
    c_stream: cover property (take ##1 take);
    c_frozen_request: cover property (!clk_en_in && op_valid_in);
endmodule
bind halfword_pack_extend_unit pack_unit_asserts chk (.*);
`default_nettype wire
